// ===== msu_defs.svh
`ifndef MSU_DEFS_SVH
`define MSU_DEFS_SVH
// Functional notes
// - client ack command 0x3 clears client flags
// - extend timeouts work only with low timeout
// - no slow clock request without low timeout
// - host debug halt stalls transaction one clock later (registered)
// - missing auto-baud stop bit flags an error
// - high-speed read NACK command forces STOP
// - collision aborts current USART transfer
// - address match flag cleared by one-write
// - smart mode data access clears data ready

// =====================================
// bus commands
`define MSU_CMD_NONE 2'h0
`define MSU_CMD_REPSTART 2'h1
`define MSU_CMD_NACK 2'h2
`define MSU_CMD_ACK 2'h3
`define MSU_CMD_STOP 2'h3

// =====================================
// flag positions
`define MSU_FLAG_W 10
`define MSU_FLAG_ADDR_MATCH 0
`define MSU_FLAG_DATA_READY 1
`define MSU_FLAG_STOP_RCVD 2
`define MSU_FLAG_SELECT_LOW 3
`define MSU_FLAG_LOW_TIMEOUT 4
`define MSU_FLAG_CLIENT_EXT 5
`define MSU_FLAG_HOST_EXT 6
`define MSU_FLAG_COLLISION 7
`define MSU_FLAG_FRAMING 8
`define MSU_FLAG_INCONS_SYNC 9
`define MSU_FLAGS_RESET 10'h000
`define MSU_CLIENT_FLAGS 10'h007

// =====================================
// values and counts
`define MSU_SYNC_BYTE 8'h55
`define MSU_PIN_IDLE 4'hF
`define MSU_LOW_TICKS 16'h0019
`define MSU_CLIENT_EXT_TICKS 16'h0019
`define MSU_HOST_EXT_TICKS 16'h000A
`define MSU_BAUD_RESET 16'h0010

`endif

// ===== msu_pkg.sv
package msu_pkg;
	typedef enum logic [2:0] {
		MSU_MODE_USART = 3'h0,
		MSU_MODE_SPI_CLIENT = 3'h1,
		MSU_MODE_SPI_HOST = 3'h2,
		MSU_MODE_I2C_CLIENT = 3'h3,
		MSU_MODE_I2C_HOST = 3'h4
	} msu_mode_type;

	typedef enum logic [3:0] {
		MSU_RX_IDLE = 4'h1,
		MSU_RX_START = 4'h2,
		MSU_RX_DATA = 4'h4,
		MSU_RX_STOP = 4'h8
	} msu_rx_state_type;
endpackage

// ===== msu_sync.sv
`timescale 1ns/1ps
module msu_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic [WIDTH-1:0] async,
	output logic [WIDTH-1:0] synced
);
	logic [WIDTH-1:0] stage_r;

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			stage_r <= INIT;
			synced <= INIT;
		end else begin
			stage_r <= async;
			synced <= stage_r;
		end
	end
endmodule

// ===== multi_protocol_serial_unit.sv
`timescale 1ns/1ps
`include "msu_defs.svh"
module multi_protocol_serial_unit #(
	parameter logic [15:0] LOW_TICKS = `MSU_LOW_TICKS,
	parameter logic [15:0] CLIENT_EXT_TICKS = `MSU_CLIENT_EXT_TICKS,
	parameter logic [15:0] HOST_EXT_TICKS = `MSU_HOST_EXT_TICKS
) (
	input wire logic clock,
	input wire logic reset,
	input wire msu_pkg::msu_mode_type mode,
	input wire logic enable,
	input wire logic debugActive,
	input wire logic haltInDebug,
	input wire logic sclLowTimeoutEnable,
	input wire logic clientExtendTimeoutEnable,
	input wire logic hostExtendTimeoutEnable,
	input wire logic slowTimeoutClock,
	output logic slowClockRequest,
	input wire logic cmdWrite,
	input wire logic [1:0] cmdValue,
	input wire logic ackActionBit,
	input wire logic highSpeed,
	input wire logic hostReading,
	input wire logic smartMode,
	input wire logic dataAccess,
	input wire logic [9:0] flagClearMask,
	input wire logic addressMatchEvent,
	input wire logic dataReadyEvent,
	output logic [9:0] flags,
	output logic clientAckStrobe,
	output logic clientAckNack,
	output logic hostNackStrobe,
	output logic hostStopStrobe,
	output logic hostRepStartStrobe,
	output logic hostStall,
	input wire logic sclIn,
	input wire logic sdaIn,
	input wire logic selectIn,
	input wire logic receiverEnable,
	input wire logic selectLowDetectEnable,
	input wire logic rxdIn,
	input wire logic autoBaudEnable,
	input wire logic [15:0] baudDivisor,
	input wire logic collisionDetectEnable,
	input wire logic txStart,
	input wire logic [7:0] txData,
	output logic txReady,
	output logic txdOut,
	output logic [7:0] rxData,
	output logic rxValid
);
	import msu_pkg::*;

	// =====================================
	// pin synchronisers and edges
	logic [3:0] pins;
	logic [3:0] prevPins_r;
	logic slowSync;
	logic slowPrev_r;
	logic scl, sda, sel, rxd;
	logic slowTick, startSeen, stopSeen, selFall, selArmed_r;
	logic isClient, isHost;

	msu_sync #(.WIDTH(4), .INIT(`MSU_PIN_IDLE)) pinSync (
		.clock(clock),
		.reset(reset),
		.async({sclIn, sdaIn, selectIn, rxdIn}),
		.synced(pins)
	);
	msu_sync #(.WIDTH(1), .INIT(1'h0)) slowSyncInst (
		.clock(clock),
		.reset(reset),
		.async(slowTimeoutClock),
		.synced(slowSync)
	);

	assign scl = pins[3];
	assign sda = pins[2];
	assign sel = pins[1];
	assign rxd = pins[0];
	assign isClient = enable && (mode == MSU_MODE_I2C_CLIENT);
	assign isHost = enable && (mode == MSU_MODE_I2C_HOST);
	assign slowTick = slowSync && !slowPrev_r;
	assign startSeen = scl && prevPins_r[3] && prevPins_r[2] && !sda;
	assign stopSeen = scl && prevPins_r[3] && !prevPins_r[2] && sda;
	assign selFall = selArmed_r && prevPins_r[1] && !sel;

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			prevPins_r <= `MSU_PIN_IDLE;
			slowPrev_r <= 1'b0;
		end else begin
			prevPins_r <= pins;
			slowPrev_r <= slowSync;
		end
	end

	// armed only a cycle after all enables, so a stale select level never fakes an edge
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			selArmed_r <= 1'b0;
		end else begin
			selArmed_r <= enable && (mode == MSU_MODE_SPI_CLIENT) && receiverEnable
				&& selectLowDetectEnable;
		end
	end

	// =====================================
	// scl low timeouts
	logic [15:0] lowCnt_r, extCnt_r;
	logic lowHit, clientExtHit, hostExtHit;

	assign slowClockRequest = enable && sclLowTimeoutEnable
		&& (isClient || isHost);
	assign lowHit = slowClockRequest && slowTick && !scl && (lowCnt_r == LOW_TICKS - 16'h1);
	assign clientExtHit = slowClockRequest && clientExtendTimeoutEnable && isClient
		&& slowTick && !scl && (extCnt_r == CLIENT_EXT_TICKS - 16'h1);
	assign hostExtHit = slowClockRequest && hostExtendTimeoutEnable && isHost
		&& slowTick && !scl && (extCnt_r == HOST_EXT_TICKS - 16'h1);

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			lowCnt_r <= 16'h0000;
			extCnt_r <= 16'h0000;
		end else if (!slowClockRequest || startSeen || stopSeen) begin
			lowCnt_r <= 16'h0000;
			extCnt_r <= 16'h0000;
		end else begin
			if (scl) begin
				lowCnt_r <= 16'h0000;
			end else if (slowTick && lowCnt_r != 16'hFFFF) begin
				lowCnt_r <= lowCnt_r + 16'h1;
			end
			if (!scl && slowTick && extCnt_r != 16'hFFFF) begin
				extCnt_r <= extCnt_r + 16'h1;
			end
		end
	end

	// =====================================
	// bus commands
	logic ackCmd, nackCmd;
	assign ackCmd = isClient && cmdWrite && (cmdValue == `MSU_CMD_ACK);
	assign nackCmd = isHost && cmdWrite && (cmdValue == `MSU_CMD_NACK);

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			clientAckStrobe <= 1'b0;
			clientAckNack <= 1'b0;
			hostNackStrobe <= 1'b0;
			hostStopStrobe <= 1'b0;
			hostRepStartStrobe <= 1'b0;
		end else begin
			clientAckStrobe <= ackCmd;
			if (ackCmd) begin
				clientAckNack <= ackActionBit;
			end
			hostNackStrobe <= nackCmd;
			hostStopStrobe <= (isHost && cmdWrite && cmdValue == `MSU_CMD_STOP)
				|| (nackCmd && highSpeed && hostReading);
			hostRepStartStrobe <= isHost && cmdWrite && (cmdValue == `MSU_CMD_REPSTART);
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			hostStall <= 1'b0;
		end else begin
			hostStall <= isHost && haltInDebug && debugActive;
		end
	end

	// =====================================
	// usart receiver
	msu_rx_state_type rxState_r;
	logic [15:0] rxCnt_r;
	logic [2:0] rxBits_r;
	logic [7:0] rxShift_r;
	logic syncExpect_r, autoPrev_r, stopCheck, framingSet, inconsSet;
	logic isUsart;

	assign isUsart = enable && (mode == MSU_MODE_USART);
	assign stopCheck = (rxState_r == MSU_RX_STOP) && (rxCnt_r == 16'h0000);
	assign inconsSet = stopCheck && syncExpect_r
		&& (!rxd || rxShift_r != `MSU_SYNC_BYTE);
	assign framingSet = stopCheck && !syncExpect_r && !rxd;

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			rxState_r <= MSU_RX_IDLE;
			rxCnt_r <= 16'h0000;
			rxBits_r <= 3'h0;
			rxShift_r <= 8'h00;
		end else if (!isUsart || !receiverEnable) begin
			rxState_r <= MSU_RX_IDLE;
		end else begin
			unique case (rxState_r)
				MSU_RX_IDLE: begin
					if (!rxd) begin
						rxState_r <= MSU_RX_START;
						rxCnt_r <= {1'b0, baudDivisor[15:1]};
					end
				end
				MSU_RX_START: begin
					if (rxCnt_r != 16'h0000) begin
						rxCnt_r <= rxCnt_r - 16'h1;
					end else if (rxd) begin
						rxState_r <= MSU_RX_IDLE;
					end else begin
						rxState_r <= MSU_RX_DATA;
						rxCnt_r <= baudDivisor;
						rxBits_r <= 3'h0;
					end
				end
				MSU_RX_DATA: begin
					if (rxCnt_r != 16'h0000) begin
						rxCnt_r <= rxCnt_r - 16'h1;
					end else begin
						rxShift_r <= {rxd, rxShift_r[7:1]};
						rxBits_r <= rxBits_r + 3'h1;
						rxCnt_r <= baudDivisor;
						if (rxBits_r == 3'h7) begin
							rxState_r <= MSU_RX_STOP;
						end
					end
				end
				MSU_RX_STOP: begin
					if (rxCnt_r != 16'h0000) begin
						rxCnt_r <= rxCnt_r - 16'h1;
					end else begin
						rxState_r <= MSU_RX_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			syncExpect_r <= 1'b0;
			autoPrev_r <= 1'b0;
			rxData <= 8'h00;
			rxValid <= 1'b0;
		end else begin
			autoPrev_r <= autoBaudEnable;
			rxValid <= stopCheck && rxd && !inconsSet;
			if (stopCheck && rxd) begin
				rxData <= rxShift_r;
			end
			// a break re-arms the sync field check
			if (autoBaudEnable && (!autoPrev_r || framingSet)) begin
				syncExpect_r <= 1'b1;
			end else if (stopCheck || !autoBaudEnable) begin
				syncExpect_r <= 1'b0;
			end
		end
	end

	// =====================================
	// usart transmitter with collision abort
	logic txBusy_r;
	logic [9:0] txShift_r;
	logic [3:0] txBits_r;
	logic [15:0] txCnt_r;
	logic collide;

	assign txReady = isUsart && !txBusy_r;
	assign collide = txBusy_r && collisionDetectEnable
		&& (txCnt_r == {1'b0, baudDivisor[15:1]}) && (rxd != txdOut);

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			txBusy_r <= 1'b0;
			txShift_r <= 10'h3FF;
			txBits_r <= 4'h0;
			txCnt_r <= 16'h0000;
			txdOut <= 1'b1;
		end else if (collide || !isUsart) begin
			txBusy_r <= 1'b0;
			txdOut <= 1'b1;
		end else if (txStart && txReady) begin
			txBusy_r <= 1'b1;
			txShift_r <= {1'b1, txData, 1'b0};
			txBits_r <= 4'h0;
			txCnt_r <= baudDivisor;
			txdOut <= 1'b0;
		end else if (txBusy_r) begin
			if (txCnt_r != 16'h0000) begin
				txCnt_r <= txCnt_r - 16'h1;
			end else if (txBits_r == 4'h9) begin
				txBusy_r <= 1'b0;
				txdOut <= 1'b1;
			end else begin
				txBits_r <= txBits_r + 4'h1;
				txShift_r <= {1'b1, txShift_r[9:1]};
				txdOut <= txShift_r[1];
				txCnt_r <= baudDivisor;
			end
		end
	end

	// =====================================
	// interrupt flags, set wins over clear
	logic [9:0] flagSet, flagClr;

	always_comb begin
		flagSet = `MSU_FLAGS_RESET;
		flagSet[`MSU_FLAG_ADDR_MATCH] = isClient && addressMatchEvent;
		flagSet[`MSU_FLAG_DATA_READY] = isClient && dataReadyEvent;
		flagSet[`MSU_FLAG_STOP_RCVD] = isClient && stopSeen;
		flagSet[`MSU_FLAG_SELECT_LOW] = selFall;
		flagSet[`MSU_FLAG_LOW_TIMEOUT] = lowHit;
		flagSet[`MSU_FLAG_CLIENT_EXT] = clientExtHit;
		flagSet[`MSU_FLAG_HOST_EXT] = hostExtHit;
		flagSet[`MSU_FLAG_COLLISION] = collide;
		flagSet[`MSU_FLAG_FRAMING] = framingSet;
		flagSet[`MSU_FLAG_INCONS_SYNC] = inconsSet;
		flagClr = flagClearMask;
		if (ackCmd) begin
			flagClr = flagClr | `MSU_CLIENT_FLAGS;
		end
		if (smartMode && dataAccess) begin
			flagClr[`MSU_FLAG_DATA_READY] = 1'b1;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			flags <= `MSU_FLAGS_RESET;
		end else begin
			flags <= (flags & ~flagClr) | flagSet;
		end
	end

	// =====================================
	// assertions
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	a_ack_clears_flags: assert property (ackCmd && !flagSet[2] && !flagSet[1] && !flagSet[0]
		|=> flags[2:0] == 3'h0) else $error("ack command left client flags set");
	a_ext_needs_low: assert property ($rose(flags[`MSU_FLAG_CLIENT_EXT])
		|-> $past(sclLowTimeoutEnable)) else $error("extend timeout without low timeout");
	a_slow_request_off: assert property (!sclLowTimeoutEnable |-> !slowClockRequest)
		else $error("slow clock requested while timeout disabled");
	a_debug_stall: assert property (isHost && haltInDebug && debugActive |=> hostStall)
		else $error("host did not stall in debug");
	a_stop_bit_err: assert property (stopCheck && !rxd
		|=> flags[`MSU_FLAG_FRAMING] || flags[`MSU_FLAG_INCONS_SYNC])
		else $error("missing stop bit not flagged");
	a_hs_nack_stop: assert property (nackCmd && highSpeed && hostReading
		|=> hostStopStrobe && hostNackStrobe) else $error("nack did not force stop");
	a_collision_abort: assert property (collide |=> !txBusy_r && txdOut
		&& flags[`MSU_FLAG_COLLISION]) else $error("collision did not abort");
	a_addr_clear: assert property (flagClearMask[0] && !flagSet[0]
		|=> !flags[`MSU_FLAG_ADDR_MATCH]) else $error("address match not cleared");
	a_smart_clear: assert property (smartMode && dataAccess && !flagSet[1]
		|=> !flags[`MSU_FLAG_DATA_READY]) else $error("smart access left data ready");
	a_ack_response: assert property (ackCmd |=> clientAckStrobe
		&& clientAckNack == $past(ackActionBit)) else $error("wrong ack response");
	a_select_fall: assert property (selFall |=> flags[`MSU_FLAG_SELECT_LOW])
		else $error("select fall not flagged");

	c_ack_cmd: cover property (ackCmd ##1 clientAckStrobe);
	c_rx_frame: cover property (rxValid);
	c_collision: cover property (collide);
	c_low_timeout: cover property (lowHit);
endmodule

// ===== msu_peer_model.sv
`timescale 1ns/1ps
module msu_peer_model #(
	parameter int BIT_CYCLES = 16
) (
	input wire logic clock,
	output logic rxd,
	output logic select,
	output logic scl,
	output logic sda
);
	// pins idle at their pull-up level
	initial begin
		rxd = 1'b1;
		select = 1'b1;
		scl = 1'b1;
		sda = 1'b1;
	end

	// =====================================
	// usart frame, start, lsb first, stop
	task automatic send_byte(input logic [7:0] data, input logic stopHigh);
		logic [9:0] frame;
		frame = {stopHigh, data, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(negedge clock);
			rxd = frame[i];
			repeat (BIT_CYCLES - 1) @(negedge clock);
		end
		@(negedge clock);
		rxd = 1'b1;
	endtask

	// =====================================
	// i2c and spi pin sequences
	task automatic start_stop();
		@(negedge clock);
		sda = 1'b0;
		repeat (6) @(negedge clock);
		sda = 1'b1;
		repeat (6) @(negedge clock);
	endtask

	task automatic hold_scl_low(input int cycles);
		@(negedge clock);
		scl = 1'b0;
		repeat (cycles) @(negedge clock);
		scl = 1'b1;
	endtask

	task automatic drop_select(input int cycles);
		@(negedge clock);
		select = 1'b0;
		repeat (cycles) @(negedge clock);
		select = 1'b1;
	endtask
endmodule

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
	import msu_pkg::*;
	logic clock = 0, reset = 1, enable = 0, debugActive = 0, haltInDebug = 0, lowTo = 0;
	logic cExt = 0, hExt = 0, slowClk = 0, cmdWrite = 0, ackBit = 0, highSpeed = 0;
	logic hostReading = 0, smartMode = 0, dataAccess = 0, amEv = 0, drEv = 0, receiver_enable = 0;
	logic sldEn = 0, abEn = 0, colEn = 0, txStart = 0, echo = 0;
	logic [1:0] cmdValue = 0;
	logic [9:0] clrMask = 0;
	logic [7:0] txData = 0, rxData;
	logic [15:0] baudDiv = 16'h000F;
	msu_mode_type mode = MSU_MODE_I2C_CLIENT;
	logic slowReq, ackStb, ackNack, nackStb, stopStb, repStb, hostStall, txReady, txdOut, rxValid;
	logic peerRxd, selectIn, sclIn, sdaIn;
	logic [9:0] flags;
	wire logic rxdIn = echo ? txdOut : peerRxd;
	int errCount = 0, totalChecks = 0, cycles = 0;

	multi_protocol_serial_unit #(.LOW_TICKS(16'h0004), .CLIENT_EXT_TICKS(16'h0003),
		.HOST_EXT_TICKS(16'h0002)) dut (.clock(clock), .reset(reset), .mode(mode),
		.enable(enable), .debugActive(debugActive), .haltInDebug(haltInDebug),
		.sclLowTimeoutEnable(lowTo), .clientExtendTimeoutEnable(cExt),
		.hostExtendTimeoutEnable(hExt), .slowTimeoutClock(slowClk), .slowClockRequest(slowReq),
		.cmdWrite(cmdWrite), .cmdValue(cmdValue), .ackActionBit(ackBit), .highSpeed(highSpeed),
		.hostReading(hostReading), .smartMode(smartMode), .dataAccess(dataAccess),
		.flagClearMask(clrMask), .addressMatchEvent(amEv), .dataReadyEvent(drEv),
		.flags(flags), .clientAckStrobe(ackStb), .clientAckNack(ackNack),
		.hostNackStrobe(nackStb), .hostStopStrobe(stopStb), .hostRepStartStrobe(repStb),
		.hostStall(hostStall), .sclIn(sclIn), .sdaIn(sdaIn), .selectIn(selectIn),
		.receiverEnable(receiver_enable), .selectLowDetectEnable(sldEn), .rxdIn(rxdIn),
		.autoBaudEnable(abEn), .baudDivisor(baudDiv), .collisionDetectEnable(colEn),
		.txStart(txStart), .txData(txData), .txReady(txReady), .txdOut(txdOut),
		.rxData(rxData), .rxValid(rxValid));

	msu_peer_model #(.BIT_CYCLES(16)) peer (.clock(clock), .rxd(peerRxd), .select(selectIn),
		.scl(sclIn), .sda(sdaIn));

	initial begin
		forever #12.5 clock = ~clock;
	end

	// slow generator clock, unrelated in phase
	initial begin
		#37;
		forever #100 slowClk = ~slowClk;
	end

	// =====================================
	// checking and closing
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		totalChecks++;
		if (got !== exp) begin
			errCount++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task end_of_test;
		$display("checks %0d mismatches %0d", totalChecks, errCount);
		if (errCount == 0 && totalChecks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	function automatic logic exp_req(msu_mode_type m, logic en, logic lt);
		return en & lt & (m == MSU_MODE_I2C_CLIENT || m == MSU_MODE_I2C_HOST);
	endfunction

	task automatic cmd(input logic [1:0] v);
		@(negedge clock);
		cmdWrite = 1;
		cmdValue = v;
		@(negedge clock);
		cmdWrite = 0;
	endtask

	task automatic client_events();
		@(negedge clock);
		amEv = 1;
		drEv = 1;
		@(negedge clock);
		amEv = 0;
		drEv = 0;
	endtask

	task automatic wait_high(input bit useReady, input int limit);
		for (int n = 0; n < limit && (useReady ? txReady : rxValid) !== 1'b1; n++) begin
			@(negedge clock);
		end
	endtask

	always @(posedge clock) begin
		cycles++;
		if (cycles == 12000) begin
			errCount++;
			end_of_test();
		end
	end

	// =====================================
	// main sequence
	initial begin
		void'($urandom(32'h5EA8));
		repeat (8) @(negedge clock);
		reset = 0;
		check("flags", 16'h0000, flags);
		check("txdOut", 16'h0001, txdOut);
		check("hostStall", 16'h0000, hostStall);
		for (int i = 0; i < 24; i++) begin
			@(negedge clock);
			mode = msu_mode_type'($urandom_range(4));
			enable = $urandom;
			lowTo = $urandom;
			#1 check("slowClockRequest", exp_req(mode, enable, lowTo), slowReq);
		end
		$display("test clock request done");
		mode = MSU_MODE_I2C_CLIENT;
		enable = 1;
		lowTo = 0;
		client_events();
		check("match and ready", 16'h0003, flags[1:0]);
		clrMask = 10'h001;
		@(negedge clock);
		clrMask = 0;
		check("match after clear", 16'h0002, flags[1:0]);
		dataAccess = 1;
		@(negedge clock);
		dataAccess = 0;
		check("ready plain access", 16'h0001, flags[1]);
		smartMode = 1;
		dataAccess = 1;
		@(negedge clock);
		dataAccess = 0;
		smartMode = 0;
		check("ready smart access", 16'h0000, flags[1]);
		for (int k = 0; k < 2; k++) begin
			client_events();
			peer.start_stop();
			check("stop received", 16'h0001, flags[2]);
			ackBit = k[0];
			cmd(`MSU_CMD_ACK);
			check("ack strobe", 16'h0001, ackStb);
			check("ack nack", {15'h0000, k[0]}, ackNack);
			check("client flags", 16'h0000, flags[2:0]);
		end
		$display("test client done");
		mode = MSU_MODE_I2C_HOST;
		highSpeed = 1;
		hostReading = 1;
		cmd(`MSU_CMD_NACK);
		check("nack strobe", 16'h0001, nackStb);
		check("forced stop", 16'h0001, stopStb);
		highSpeed = 0;
		cmd(`MSU_CMD_REPSTART);
		check("repeated start", 16'h0001, repStb);
		check("no stop", 16'h0000, stopStb);
		cmd(`MSU_CMD_NACK);
		check("plain nack stop", 16'h0000, stopStb);
		cmd(`MSU_CMD_STOP);
		check("stop command", 16'h0001, stopStb);
		haltInDebug = 1;
		debugActive = 1;
		@(negedge clock);
		check("stall", 16'h0001, hostStall);
		debugActive = 0;
		@(negedge clock);
		check("stall released", 16'h0000, hostStall);
		haltInDebug = 0;
		debugActive = 1;
		@(negedge clock);
		check("no stall without halt", 16'h0000, hostStall);
		debugActive = 0;
		$display("test host done");
		mode = MSU_MODE_I2C_CLIENT;
		cExt = 1;
		hExt = 1;
		peer.hold_scl_low(120);
		check("timeouts disabled", 16'h0000, flags[5:4]);
		lowTo = 1;
		peer.hold_scl_low(120);
		check("timeouts enabled", 16'h0003, flags[5:4]);
		clrMask = 10'h3FF;
		@(negedge clock);
		clrMask = 0;
		mode = MSU_MODE_I2C_HOST;
		cExt = 0;
		peer.start_stop();
		peer.hold_scl_low(120);
		check("host timeouts", 16'h0005, flags[6:4]);
		clrMask = 10'h3FF;
		@(negedge clock);
		clrMask = 0;
		$display("test timeout done");
		mode = MSU_MODE_SPI_CLIENT;
		sldEn = 1;
		@(negedge clock);
		receiver_enable = 1;
		repeat (6) @(negedge clock);
		check("no false select", 16'h0000, flags[3]);
		peer.drop_select(8);
		check("select low", 16'h0001, flags[3]);
		$display("test select done");
		mode = MSU_MODE_USART;
		colEn = 1;
		echo = 1;
		for (int j = 0; j < 4; j++) begin
			txData = (j == 0) ? 8'h00 : (j == 1) ? 8'hFF : 8'($urandom);
			baudDiv = 16'($urandom_range(31, 8));
			@(negedge clock);
			txStart = 1;
			@(negedge clock);
			txStart = 0;
			wait_high(1'b0, 400);
			check("rxValid", 16'h0001, rxValid);
			check("rxData", {8'h00, txData}, rxData);
			check("no collision", 16'h0000, flags[7]);
			wait_high(1'b1, 400);
		end
		echo = 0;
		baudDiv = 16'h000F;
		colEn = 0;
		for (int c = 0; c < 2; c++) begin
			@(negedge clock);
			txStart = 1;
			@(negedge clock);
			txStart = 0;
			repeat (14) @(negedge clock);
			if (c == 0) begin
				check("no abort", 16'h0000, {txReady, flags[7]});
				wait_high(1'b1, 400);
				colEn = 1;
			end
		end
		check("collision", 16'h0001, flags[7]);
		check("aborted ready", 16'h0001, txReady);
		check("aborted line", 16'h0001, txdOut);
		$display("test usart done");
		abEn = 1;
		peer.send_byte(`MSU_SYNC_BYTE, 1'b0);
		repeat (20) @(negedge clock);
		check("missing stop", 16'h0001, flags[8] | flags[9]);
		$display("test auto baud done");
		end_of_test();
	end
endmodule
